// ### design/dual_hex_switch_output_control.sv
// What this block does
// R1 - dual mode: input zero drives outputs 0, 4, 5; hex: only output 0
// R2 - hex mode: input one drives output 1, input two drives output 2
// R3 - dual mode: input one drives outputs 1, 2 and 3 together
// R4 - mid-level on input two held beyond mode filter time selects dual mode
// R5 - dual mode: serial turns group 0,4,5 on only if bits 0,4,5 all set
// R6 - dual mode: serial turns group 1,2,3 on only if bits 1,2,3 all set
// R7 - hex mode: outputs 0-2 are pin OR serial bit; 3-5 serial only
// R8 - enable high disables serial control, pins still drive; full control and fault detection need enable low
// R9 - on-output in current limit beyond fault filter time flags short fault
// R10 - short fault turns output off for refresh period, then retries
// R11 - off-output below threshold beyond open filter time flags open load
// R12 - faults latch per channel and shift out in next serial transfer
// R13 - one transfer is exactly eight bits: commands in, diagnostics out
// R14 - command bit 7 set with enable high puts device into sleep
// R15 - power-up or wake from sleep holds outputs off for wake-up period
// R16 - serial in sampled on rising clock, serial out changes on falling
// R17 - chip select rise clears faults and adopts received command word
// R18 - mid-level indication arrives as a synchronous comparator qualifier
`timescale 1ns/1ps
`default_nettype none
module dual_hex_switch_output_control #(
	parameter int MODE_CYC    = hex_switch_pkg::MODE_CYCLES,
	parameter int WAKE_CYC    = hex_switch_pkg::WAKE_CYCLES,
	parameter int SHORT_CYC   = hex_switch_pkg::SHORT_FILT_CYCLES,
	parameter int OPEN_CYC    = hex_switch_pkg::OPEN_FILT_CYCLES,
	parameter int REFRESH_CYC = hex_switch_pkg::REFRESH_CYCLES
) (
	// clock and reset
	input  wire logic                           clk_sys_i,
	input  wire logic                           reset_i,
	// serial link
	input  wire logic                           sclk_i,
	input  wire logic                           cs_n_i,
	input  wire logic                           si_i,
	output logic                                so_o,
	output logic                                so_oe_o,
	// parallel control pins
	input  wire logic                           en_n_i,
	input  wire logic                           par_in_zero_i,
	input  wire logic                           par_in_one_i,
	input  wire logic                           par_in_two_mode_sel_i,
	input  wire logic                           mid_level_i,
	// analog sense
	input  wire logic [hex_switch_pkg::NCH-1:0] cur_limit_i,
	input  wire logic [hex_switch_pkg::NCH-1:0] below_thresh_i,
	input  wire logic                           overvoltage_sense_input_i,
	// outputs and status
	output logic      [hex_switch_pkg::NCH-1:0] switch_outputs_o,
	output logic      [hex_switch_pkg::NCH-1:0] fault_o,
	output logic                                dual_mode_o,
	output logic                                sleep_o
);
	import hex_switch_pkg::*;

	localparam int FILT_MAX = (SHORT_CYC > OPEN_CYC) ? SHORT_CYC : OPEN_CYC;
	localparam int MODE_W   = $clog2(MODE_CYC + 1);
	localparam int WAKE_W   = $clog2(WAKE_CYC + 1);
	localparam int FILT_W   = $clog2(FILT_MAX + 1);
	localparam int REF_W    = $clog2(REFRESH_CYC + 1);

	localparam logic [MODE_W-1:0] MODE_TOP  = MODE_W'(MODE_CYC);
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYC - 1);
	localparam logic [FILT_W-1:0] SHORT_TOP = FILT_W'(SHORT_CYC);
	localparam logic [FILT_W-1:0] OPEN_TOP  = FILT_W'(OPEN_CYC);
	localparam logic [REF_W-1:0]  REF_TOP   = REF_W'(REFRESH_CYC);
	localparam logic [CNT_W-1:0]  CNT_FULL  = CNT_W'(SPI_BITS);
	localparam logic [CNT_W-1:0]  CNT_MAX   = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0]  CNT_PRE   = CNT_W'(SPI_BITS - 1);

	if (MODE_CYC < 1 || WAKE_CYC < 1 || SHORT_CYC < 1 || OPEN_CYC < 1 ||
		REFRESH_CYC < 1 || NCH != 6 || CMD_W != SPI_BITS) begin : g_check
		$error("timing counts must be at least one cycle");
	end

	typedef struct packed {
		logic [SY_W-1:0]               sync1;
		logic [SY_W-1:0]               sync2;
		logic                          cs_prev;
		pwr_state_t                    pwr;
		logic [WAKE_W-1:0]             wake_cnt;
		logic [MODE_W-1:0]             mode_cnt;
		logic                          dual;
		logic [CMD_W-1:0]              cmd;
		logic [NCH-1:0]                fault;
		logic [NCH-1:0][FILT_W-1:0]    filt_cnt;
		logic [NCH-1:0][REF_W-1:0]     ref_cnt;
		logic [CMD_W-1:0]              snap;
		logic [NCH-1:0]                outs;
		logic                          sleeping;
	} state_t;

	localparam state_t ST_RESET = '0;

	state_t r;
	state_t nxt;

	// link-side registers
	logic [CMD_W-1:0] rx_r;
	logic [CNT_W-1:0] rx_cnt_r;
	logic             rx_started_r;
	logic [CNT_W-1:0] tx_cnt_r;
	logic             so_r;

	// decoded synchronised inputs and derived control terms
	logic [NCH-1:0] cur_s;
	logic [NCH-1:0] below_s;
	logic           cs_n_s;
	logic           p0_s;
	logic           p1_s;
	logic           p2_s;
	logic           en_n_s;
	logic           ov_s;
	logic           cs_rise;
	logic           active;
	logic           det_en;
	logic           grp0;
	logic           grp1;
	logic [NCH-1:0] req;
	logic           drive;

	always_comb begin
		nxt = r;
		nxt.sync1 = {overvoltage_sense_input_i, en_n_i,
			par_in_two_mode_sel_i, par_in_one_i, par_in_zero_i, cs_n_i,
			below_thresh_i, cur_limit_i};
		nxt.sync2 = r.sync1;

		cur_s   = r.sync2[SY_CUR +: NCH];
		below_s = r.sync2[SY_BELOW +: NCH];
		cs_n_s  = r.sync2[SY_CS_N];
		p0_s    = r.sync2[SY_P0];
		p1_s    = r.sync2[SY_P1];
		p2_s    = r.sync2[SY_P2];
		en_n_s  = r.sync2[SY_EN_N];
		ov_s    = r.sync2[SY_OV];

		// R17 chip select rise
		cs_rise     = cs_n_s & ~r.cs_prev;
		nxt.cs_prev = cs_n_s;

		// R12 snapshot frozen while a frame runs
		if (cs_n_s) begin
			nxt.snap = {{(CMD_W - NCH){1'b0}}, r.fault};
		end

		// R4 R18 mode filter on qualifier
		if (mid_level_i && r.pwr != PWR_SLEEP) begin
			if (r.mode_cnt == MODE_TOP) begin
				nxt.dual = 1'b1;
			end else begin
				nxt.mode_cnt = r.mode_cnt + 1'b1;
			end
		end else begin
			nxt.mode_cnt = '0;
		end

		case (r.pwr)
			// R15 wake-up dead time
			PWR_WAKE: begin
				if (r.wake_cnt == WAKE_LAST) begin
					nxt.pwr = PWR_RUN;
				end else begin
					nxt.wake_cnt = r.wake_cnt + 1'b1;
				end
			end
			// R14 sleep entry
			PWR_RUN: begin
				if (en_n_s && r.cmd[CMD_SLEEP_BIT]) begin
					nxt.pwr = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				if (!en_n_s) begin
					nxt.pwr      = PWR_WAKE;
					nxt.wake_cnt = '0;
				end
			end
			default: begin
				nxt.pwr      = PWR_WAKE;
				nxt.wake_cnt = '0;
			end
		endcase
		nxt.sleeping = (nxt.pwr == PWR_SLEEP);

		// R13 R17 adopt only complete eight-bit words
		if (r.pwr == PWR_SLEEP) begin
			nxt.cmd = '0;
		end else if (cs_rise && rx_cnt_r == CNT_FULL) begin
			nxt.cmd = rx_r;
		end

		// R8 serial bits act only with enable low
		if (!en_n_s) begin
			// R5 R6 dual groups need all three bits
			grp0 = p0_s | (r.cmd[CMD_B0] & r.cmd[CMD_B4] & r.cmd[CMD_B5]);
			grp1 = p1_s | (r.cmd[CMD_B1] & r.cmd[CMD_B2] & r.cmd[CMD_B3]);
			// R7 hex pin or serial
			req = r.cmd[NCH-1:0] | {3'h0, p2_s, p1_s, p0_s};
		end else begin
			grp0 = p0_s;
			grp1 = p1_s;
			req  = {3'h0, p2_s, p1_s, p0_s};
		end
		if (r.dual) begin
			// R1 R3 ganged groups
			req = {grp0, grp0, grp1, grp1, grp1, grp0};
		end

		active = (r.pwr == PWR_RUN) && !ov_s;
		// R8 fault detection with enable low only
		det_en = active && !en_n_s;

		// R17 clear first so a same-cycle fault still lands
		if (cs_rise || r.pwr == PWR_SLEEP) begin
			nxt.fault = '0;
		end

		for (int i = 0; i < NCH; i++) begin
			drive = req[i] && r.ref_cnt[i] == '0 && active;
			if (r.ref_cnt[i] != '0) begin
				nxt.ref_cnt[i] = r.ref_cnt[i] - 1'b1;
			end
			if (!det_en) begin
				nxt.filt_cnt[i] = '0;
			end else if (drive && cur_s[i]) begin
				// R9 short filter
				if (r.filt_cnt[i] == SHORT_TOP) begin
					nxt.fault[i]    = 1'b1;
					nxt.filt_cnt[i] = '0;
					// R10 refresh off time before retry
					nxt.ref_cnt[i]  = REF_TOP;
				end else begin
					nxt.filt_cnt[i] = r.filt_cnt[i] + 1'b1;
				end
			end else if (!req[i] && below_s[i]) begin
				// R11 open-load filter
				if (r.filt_cnt[i] >= OPEN_TOP) begin
					nxt.fault[i] = 1'b1;
				end else begin
					nxt.filt_cnt[i] = r.filt_cnt[i] + 1'b1;
				end
			end else begin
				nxt.filt_cnt[i] = '0;
			end
			nxt.outs[i] = drive;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			r <= ST_RESET;
		end else begin
			r <= nxt;
		end
	end

	// frame start marker, cleared while chip select is high
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rx_started_r <= 1'b0;
		end else begin
			rx_started_r <= 1'b1;
		end
	end

	// R16 receive on rising edge
	always_ff @(posedge sclk_i) begin
		if (!cs_n_i) begin
			rx_r <= {rx_r[CMD_W-2:0], si_i};
			if (!rx_started_r) begin
				rx_cnt_r <= CNT_W'(1);
			end else if (rx_cnt_r != CNT_MAX) begin
				rx_cnt_r <= rx_cnt_r + 1'b1;
			end
		end
	end

	// R16 R12 transmit on falling edge, then pass received bits through
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			tx_cnt_r <= '0;
			so_r     <= 1'b0;
		end else begin
			if (tx_cnt_r < CNT_PRE) begin
				so_r <= r.snap[3'(CMD_SLEEP_BIT - 1) - tx_cnt_r[2:0]];
			end else begin
				so_r <= rx_r[CMD_W-1];
			end
			if (tx_cnt_r != CNT_MAX) begin
				tx_cnt_r <= tx_cnt_r + 1'b1;
			end
		end
	end

	// top bit shows before the first falling edge
	assign so_o    = (tx_cnt_r == '0) ? r.snap[CMD_SLEEP_BIT] : so_r;
	assign so_oe_o = ~cs_n_i;

	assign switch_outputs_o = r.outs;
	assign fault_o          = r.fault;
	assign dual_mode_o      = r.dual;
	assign sleep_o          = r.sleeping;

endmodule : dual_hex_switch_output_control
`default_nettype wire

// ### design/hex_switch_pkg.sv
package hex_switch_pkg;

	// channel and word sizes
	localparam int NCH      = 6;
	localparam int CMD_W    = 8;
	localparam int SPI_BITS = 8;
	localparam int CNT_W    = 4;

	// command word bit positions
	localparam int CMD_SLEEP_BIT = 7;
	localparam int CMD_B0        = 0;
	localparam int CMD_B1        = 1;
	localparam int CMD_B2        = 2;
	localparam int CMD_B3        = 3;
	localparam int CMD_B4        = 4;
	localparam int CMD_B5        = 5;

	// synchroniser vector layout
	localparam int SY_CUR   = 0;
	localparam int SY_BELOW = 6;
	localparam int SY_CS_N  = 12;
	localparam int SY_P0    = 13;
	localparam int SY_P1    = 14;
	localparam int SY_P2    = 15;
	localparam int SY_EN_N  = 16;
	localparam int SY_OV    = 17;
	localparam int SY_W     = 18;

	// timing
	localparam int  CLK_HZ        = 10_000_000;
	localparam int  CYC_PER_US    = CLK_HZ / 1_000_000;
	localparam int  MODE_TIME_US  = 10;
	localparam int  WAKE_TIME_US  = 40;
	localparam int  SHORT_FILT_US = 50;
	localparam int  OPEN_FILT_US  = 50;
	localparam real REFRESH_MS    = 4.1;

	// mode filter must be exceeded, hence one extra cycle
	localparam int MODE_CYCLES       = MODE_TIME_US * CYC_PER_US + 1;
	localparam int WAKE_CYCLES       = WAKE_TIME_US * CYC_PER_US;
	localparam int SHORT_FILT_CYCLES = SHORT_FILT_US * CYC_PER_US;
	localparam int OPEN_FILT_CYCLES  = OPEN_FILT_US * CYC_PER_US;
	localparam int REFRESH_CYCLES    =
		int'(REFRESH_MS * 1000.0 * CYC_PER_US);

	typedef enum logic [1:0] {
		PWR_WAKE  = 2'b00,
		PWR_RUN   = 2'b01,
		PWR_SLEEP = 2'b10
	} pwr_state_t;

endpackage : hex_switch_pkg

// ### verification/hex_switch_props.sv
`timescale 1ns/1ps
`default_nettype none
module hex_switch_props (
	input wire logic       clk_sys_i,
	input wire logic       reset_i,
	input wire logic       cs_n_i,
	input wire logic       en_n_i,
	input wire logic       mid_level_i,
	input wire logic [5:0] cur_limit_i,
	input wire logic [5:0] below_thresh_i,
	input wire logic       so_oe_o,
	input wire logic [5:0] switch_outputs_o,
	input wire logic [5:0] fault_o,
	input wire logic       dual_mode_o,
	input wire logic       sleep_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	AST_SO_EN: assert property (so_oe_o == !cs_n_i)
		else $error("so enable wrong");
	AST_WAKE: assert property ($fell(reset_i) |->
		(switch_outputs_o == 6'h00) [*8]) else $error("on during wake");
	AST_SLEEP: assert property (sleep_o && $past(sleep_o) |->
		switch_outputs_o == 6'h00) else $error("on in sleep");
	AST_GANG: assert property (dual_mode_o && $past(dual_mode_o) |->
		switch_outputs_o[0] == switch_outputs_o[4]
		&& switch_outputs_o[0] == switch_outputs_o[5]
		&& switch_outputs_o[1] == switch_outputs_o[2]
		&& switch_outputs_o[1] == switch_outputs_o[3])
		else $error("group split");
	AST_MODE: assert property (mid_level_i [*8] |=> dual_mode_o)
		else $error("dual not set");
	AST_MODE_CAUSE: assert property ($rose(dual_mode_o) |->
		$past(mid_level_i, 2)) else $error("dual without mid level");
	AST_SHORT: assert property ($rose(cur_limit_i[0])
		&& switch_outputs_o[0] && !en_n_i ##1 cur_limit_i[0] [*8]
		##1 cur_limit_i[0] [*6] |-> fault_o[0]) else $error("no short");
	AST_OPEN: assert property ($rose(below_thresh_i[3])
		&& !switch_outputs_o[3] && !en_n_i ##1 below_thresh_i[3] [*8]
		##1 below_thresh_i[3] [*6] |-> fault_o[3]) else $error("no open");
	AST_CLEAR: assert property ($rose(cs_n_i) && !sleep_o |->
		##[1:6] fault_o == 6'h00) else $error("faults kept");
endmodule : hex_switch_props
bind dual_hex_switch_output_control hex_switch_props props (.*);
`default_nettype wire

// ### verification/host_link.sv
`timescale 1ns/1ps
`default_nettype none
module host_link (
	// serial link
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	task xfer(input logic [7:0] w, input int n, output logic [7:0] r);
		r = 8'h00;
		#7;
		cs_n_o = 1'b0;
		#400;
		for (int i = 0; i < n; i++) begin
			si_o = w[3'(7 - i)];
			#16;
			sclk_o = 1'b1;
			r = {r[6:0], so_i};
			#16;
			sclk_o = 1'b0;
		end
		#16;
		si_o = ~si_o;
		cs_n_o = 1'b1;
		#400;
	endtask : xfer
endmodule : host_link
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic en_n = 1'b0;
	logic mid = 1'b0;
	logic ov = 1'b0;
	logic [2:0] par = 3'h0;
	logic [5:0] cur = 6'h00;
	logic [5:0] below = 6'h00;
	logic sclk, cs_n, si, so, so_oe, dual, slp;
	logic [5:0] sw, flt;
	logic [7:0] rd;
	int errors = 0;
	int checked = 0;
	logic [7:0] dcmd [4] = '{8'h31, 8'h0E, 8'h1F, 8'h3B};
	logic [5:0] dexp [4] = '{6'h31, 6'h0E, 6'h0E, 6'h31};
	host_link host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
	dual_hex_switch_output_control #(.MODE_CYC(5), .WAKE_CYC(10),
		.SHORT_CYC(8), .OPEN_CYC(8), .REFRESH_CYC(20)) dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
		.en_n_i(en_n), .par_in_zero_i(par[0]), .par_in_one_i(par[1]),
		.par_in_two_mode_sel_i(par[2]), .mid_level_i(mid),
		.cur_limit_i(cur), .below_thresh_i(below),
		.overvoltage_sense_input_i(ov), .switch_outputs_o(sw),
		.fault_o(flt), .dual_mode_o(dual), .sleep_o(slp));
	always #50 clk_sys_i = ~clk_sys_i;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc
	task out(input logic [5:0] e);
		chk({2'h0, sw}, {2'h0, e});
	endtask : out
	task send(input logic [7:0] w);
		host.xfer(w, 8, rd);
		cyc(6);
	endtask : send
	task t_wake;
		par = 3'h1;
		cyc(5);
		out(6'h00);
		cyc(12);
		out(6'h01);
		chk({7'h0, dual}, 8'h00);
		ov = 1'b1;
		cyc(4);
		out(6'h00);
		ov = 1'b0;
		cyc(4);
		out(6'h01);
		par = 3'h0;
		cyc(4);
	endtask : t_wake
	task t_hex;
		send(8'h38);
		chk(rd, 8'h00);
		for (int p = 0; p < 8; p++) begin
			par = 3'(p);
			cyc(4);
			out({3'h7, 3'(p)});
			en_n = 1'b1;
			cyc(4);
			out({3'h0, 3'(p)});
			en_n = 1'b0;
			cyc(4);
		end
		par = 3'h0;
		host.xfer(8'hFF, 7, rd);
		cyc(6);
		out(6'h38);
	endtask : t_hex
	task t_faults;
		send(8'h01);
		cur[0] = 1'b1;
		cyc(18);
		chk({2'h0, flt}, 8'h01);
		out(6'h00);
		cur[0] = 1'b0;
		cyc(25);
		out(6'h01);
		send(8'h00);
		chk(rd, 8'h01);
		chk({2'h0, flt}, 8'h00);
		below[3] = 1'b1;
		cyc(18);
		chk({2'h0, flt}, 8'h08);
		below[3] = 1'b0;
		send(8'h00);
		chk(rd, 8'h08);
	endtask : t_faults
	task t_sleep;
		send(8'h80);
		par = 3'h1;
		cyc(4);
		out(6'h01);
		en_n = 1'b1;
		cyc(5);
		chk({7'h0, slp}, 8'h01);
		out(6'h00);
		en_n = 1'b0;
		cyc(5);
		out(6'h00);
		cyc(12);
		out(6'h01);
		par = 3'h0;
		cyc(4);
	endtask : t_sleep
	task t_dual;
		mid = 1'b1;
		cyc(10);
		mid = 1'b0;
		cyc(2);
		chk({7'h0, dual}, 8'h01);
		par = 3'h1;
		cyc(4);
		out(6'h31);
		par = 3'h2;
		cyc(4);
		out(6'h0E);
		par = 3'h0;
		for (int i = 0; i < 4; i++) begin
			send(dcmd[i]);
			out(dexp[i]);
		end
	endtask : t_dual
	task close_out;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	initial begin
		cyc(6);
		reset_i = 1'b0;
		t_wake;
		t_hex;
		t_faults;
		t_sleep;
		t_dual;
		close_out;
	end
	initial begin
		#1ms;
		errors++;
		close_out;
	end
endmodule : testbench
`default_nettype wire
